// *** pkg/cix_pkg.sv ***
package cix_pkg;

  localparam int IW = 14;
  localparam int DW = 8;
  localparam int FAW = 7;
  localparam int PCW = 13;
  localparam int PHASES = 4;
  localparam int DBIT = 7;
  localparam int BSEL_LO = 7;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam logic [DW-1:0] GLOBAL_IRQ_ENABLE_MASK = 8'h80;
  localparam logic [PCW-1:0] PC_RESET = 13'h0000;
  localparam logic [DW-1:0] W_RESET = 8'h00;
  localparam logic [DW-1:0] OPT_RESET = 8'hff;

  localparam logic [3:0] BIT_CLEAR_OP = 4'h4;
  localparam logic [3:0] BIT_SET_OP = 4'h5;
  localparam logic [3:0] BIT_TEST_SKIP_IF_ZERO_OP = 4'h6;
  localparam logic [5:0] XOR_LITERAL_OP = 6'h3a;
  localparam logic [5:0] XOR_FILE_OP = 6'h06;
  localparam logic [IW-1:0] NO_OPERATION = 14'h0000;
  localparam logic [IW-1:0] NOP_MASK = 14'h3f9f;
  localparam logic [IW-1:0] RETURN_FROM_INTERRUPT_OP = 14'h0009;
  localparam logic [IW-1:0] OPTION_LOAD_OP = 14'h0062;

  typedef enum logic [3:0] {
    CIX_Q1 = 4'b0001,
    CIX_Q2 = 4'b0010,
    CIX_Q3 = 4'b0100,
    CIX_Q4 = 4'b1000
  } cix_phase_t;

  typedef enum logic [3:0] {
    CIX_K_NOP  = 4'b0001,
    CIX_K_BIT  = 4'b0010,
    CIX_K_XOR  = 4'b0100,
    CIX_K_CTRL = 4'b1000
  } cix_kind_t;

endpackage : cix_pkg

// *** src/cix_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module cix_core
  import cix_pkg::*;
(
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           nrst,
  // Program memory fetch.
  input  wire logic [IW-1:0]  instr,
  output logic      [PCW-1:0] pc_r,
  // File register port.
  input  wire logic [DW-1:0]  file_rdata,
  output logic      [FAW-1:0] file_addr_r,
  output logic                file_rd_r,
  output logic                file_we_r,
  output logic      [DW-1:0]  file_wdata_r,
  // Interrupt return and stack.
  input  wire logic           stack_push,
  input  wire logic [PCW-1:0] stack_push_data,
  // Core state.
  output logic      [DW-1:0]  w_r,
  output logic      [DW-1:0]  option_r,
  output logic                zero_r,
  output logic                global_irq_enable_r,
  output logic                phase_q1_r,
  output logic                flush_r
);

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------

  cix_phase_t ph_r;
  cix_phase_t ph_nxt;

  always_comb begin
    case (ph_r)
      CIX_Q1:  ph_nxt = CIX_Q2;
      CIX_Q2:  ph_nxt = CIX_Q3;
      CIX_Q3:  ph_nxt = CIX_Q4;
      CIX_Q4:  ph_nxt = CIX_Q1;
      default: ph_nxt = CIX_Q1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ph_r <= CIX_Q1;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------

  function automatic cix_kind_t kind_of(input logic [IW-1:0] op);
    if (op[13:12] == 2'b01 && op[11:10] != 2'b11) begin
      kind_of = CIX_K_BIT;
    end else if (op[13:8] == XOR_LITERAL_OP || op[13:8] == XOR_FILE_OP) begin
      kind_of = CIX_K_XOR;
    end else if (op == RETURN_FROM_INTERRUPT_OP || op == OPTION_LOAD_OP) begin
      kind_of = CIX_K_CTRL;
    end else begin
      kind_of = CIX_K_NOP;
    end
  endfunction : kind_of

  function automatic logic [DW-1:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction : bit_mask

  logic [IW-1:0]  ir_r;
  logic [IW-1:0]  ir_nxt;
  logic [DW-1:0]  opnd_r;
  logic [DW-1:0]  opnd_nxt;
  logic [DW-1:0]  res_r;
  logic [DW-1:0]  res_nxt;
  logic           skip_r;
  logic           skip_nxt;
  cix_kind_t      kind;
  logic [3:0]     bop;
  logic [2:0]     bsel;
  logic           is_xlit;
  logic           is_nop;

  always_comb begin
    kind    = kind_of(ir_r);
    bop     = ir_r[13:10];
    bsel    = ir_r[BSEL_LO+2:BSEL_LO];
    is_xlit = (ir_r[13:8] == XOR_LITERAL_OP);
    is_nop  = ((ir_r & NOP_MASK) == NO_OPERATION);
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------

  logic [PCW-1:0] pc_nxt;
  logic [DW-1:0]  w_nxt;
  logic [DW-1:0]  opt_nxt;
  logic           z_nxt;
  logic           girq_nxt;
  logic           flush_nxt;
  logic [FAW-1:0] fa_nxt;
  logic           frd_nxt;
  logic           fwe_nxt;
  logic [DW-1:0]  fwd_nxt;
  logic           pop;
  logic [PCW-1:0] stack_top;

  always_comb begin
    ir_nxt    = ir_r;
    opnd_nxt  = opnd_r;
    res_nxt   = res_r;
    skip_nxt  = skip_r;
    pc_nxt    = pc_r;
    w_nxt     = w_r;
    opt_nxt   = option_r;
    z_nxt     = zero_r;
    girq_nxt  = global_irq_enable_r;
    flush_nxt = flush_r;
    fa_nxt    = file_addr_r;
    frd_nxt   = 1'b0;
    fwe_nxt   = 1'b0;
    fwd_nxt   = file_wdata_r;
    pop       = 1'b0;
    case (ph_r)
      CIX_Q1: begin
        // A flushed slot turns the fetched word into a no-op cycle.
        ir_nxt    = flush_r ? NO_OPERATION : instr;
        flush_nxt = 1'b0;
        skip_nxt  = 1'b0;
        pc_nxt    = pc_r + PCW'(1);
        fa_nxt    = instr[FAW-1:0];
      end
      CIX_Q2: begin
        opnd_nxt = is_xlit ? ir_r[DW-1:0] : file_rdata;
        frd_nxt  = (kind == CIX_K_BIT) || (kind == CIX_K_XOR && !is_xlit);
      end
      CIX_Q3: begin
        case (kind)
          CIX_K_BIT: begin
            case (bop)
              BIT_CLEAR_OP: res_nxt = opnd_r & ~bit_mask(bsel);
              BIT_SET_OP:   res_nxt = opnd_r | bit_mask(bsel);
              BIT_TEST_SKIP_IF_ZERO_OP: begin
                res_nxt  = opnd_r;
                skip_nxt = ((opnd_r & bit_mask(bsel)) == 8'h00);
              end
              default: res_nxt = opnd_r;
            endcase
          end
          CIX_K_XOR: begin
            res_nxt = w_r ^ opnd_r;
            z_nxt   = ((w_r ^ opnd_r) == 8'h00);
          end
          CIX_K_CTRL: begin
            if (ir_r == RETURN_FROM_INTERRUPT_OP) begin
              girq_nxt = 1'b1;
            end
          end
          default: res_nxt = res_r;
        endcase
      end
      CIX_Q4: begin
        case (kind)
          CIX_K_BIT: begin
            fwe_nxt = (bop != BIT_TEST_SKIP_IF_ZERO_OP);
            fwd_nxt = res_r;
            flush_nxt = skip_r;
          end
          CIX_K_XOR: begin
            if (is_xlit || !ir_r[DBIT]) begin
              w_nxt = res_r;
            end else begin
              fwe_nxt = 1'b1;
              fwd_nxt = res_r;
            end
          end
          CIX_K_CTRL: begin
            if (ir_r == RETURN_FROM_INTERRUPT_OP) begin
              pop       = 1'b1;
              pc_nxt    = stack_top;
              flush_nxt = 1'b1;
            end else begin
              opt_nxt = w_r;
            end
          end
          default: w_nxt = w_r;
        endcase
      end
      default: ir_nxt = ir_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ir_r                <= NO_OPERATION;
      opnd_r              <= '0;
      res_r               <= '0;
      skip_r              <= 1'b0;
      pc_r                <= PC_RESET;
      w_r                 <= W_RESET;
      option_r            <= OPT_RESET;
      zero_r              <= 1'b0;
      global_irq_enable_r <= 1'b0;
      flush_r             <= 1'b0;
      file_addr_r         <= '0;
      file_rd_r           <= 1'b0;
      file_we_r           <= 1'b0;
      file_wdata_r        <= '0;
      phase_q1_r          <= 1'b0;
    end else begin
      ir_r                <= ir_nxt;
      opnd_r              <= opnd_nxt;
      res_r               <= res_nxt;
      skip_r              <= skip_nxt;
      pc_r                <= pc_nxt;
      w_r                 <= w_nxt;
      option_r            <= opt_nxt;
      zero_r              <= z_nxt;
      global_irq_enable_r <= girq_nxt;
      flush_r             <= flush_nxt;
      file_addr_r         <= fa_nxt;
      file_rd_r           <= frd_nxt;
      file_we_r           <= fwe_nxt;
      file_wdata_r        <= fwd_nxt;
      phase_q1_r          <= (ph_nxt == CIX_Q1);
    end
  end

  cix_stack #(
    .DEPTH (8),
    .WIDTH (PCW)
  ) u_stack (
    .clk       (clk),
    .nrst      (nrst),
    .push      (stack_push),
    .push_data (stack_push_data),
    .pop       (pop),
    .top_r     (stack_top)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  phase_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q1 |=> ph_r == CIX_Q2 ##1 ph_r == CIX_Q3 ##1 ph_r == CIX_Q4 ##1 ph_r == CIX_Q1)
    else $error("phase sequence broken");

  pc_step_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q1 |=> pc_r == $past(pc_r) + PCW'(1))
    else $error("pc did not advance in Q1");

  dest_w_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_XOR && !is_xlit && !ir_r[DBIT]
    |=> w_r == $past(res_r) && !file_we_r)
    else $error("d=0 result not in working register");

  dest_f_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_XOR && !is_xlit && ir_r[DBIT]
    |=> file_we_r && file_wdata_r == $past(res_r))
    else $error("d=1 result not written to file");

  bit_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_BIT && bop == BIT_CLEAR_OP |=> file_we_r && !file_wdata_r[$past(bsel)])
    else $error("bit clear wrong");

  skip_flush_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_BIT && bop == BIT_TEST_SKIP_IF_ZERO_OP && skip_r
    |=> flush_r ##4 ir_r == NO_OPERATION)
    else $error("skip did not insert no-op");

  irq_return_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && ir_r == RETURN_FROM_INTERRUPT_OP
    |=> pc_r == $past(stack_top) && global_irq_enable_r && flush_r)
    else $error("interrupt return wrong");

  option_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && ir_r == OPTION_LOAD_OP |=> option_r == $past(w_r))
    else $error("option load wrong");

  xor_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q3 && kind == CIX_K_XOR |=> zero_r == (res_r == 8'h00))
    else $error("zero flag wrong");

  bit_set_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_BIT && bop == BIT_SET_OP
    |=> file_we_r && file_wdata_r[$past(bsel)])
    else $error("bit set wrong");

  test_no_write_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && kind == CIX_K_BIT && bop == BIT_TEST_SKIP_IF_ZERO_OP
    |=> !file_we_r)
    else $error("bit test wrote the file");

  xor_literal_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && is_xlit |=> w_r == $past(res_r) && !file_we_r)
    else $error("literal xor result not in working register");

  flush_slot_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q1 && flush_r |=> ir_r == NO_OPERATION)
    else $error("flushed slot not turned into a no-op");

  nop_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    ph_r == CIX_Q4 && is_nop
    |=> !file_we_r && w_r == $past(w_r) && option_r == $past(option_r))
    else $error("no-op changed core state");

endmodule : cix_core
`default_nettype wire

// *** src/cix_stack.sv ***
`timescale 1ns/1ps
`default_nettype none
module cix_stack
  import cix_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             nrst,
  // Push and pop.
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] top_r
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("cix_stack depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    sp_r;
  logic [AW-1:0]    sp_nxt;
  logic [AW-1:0]    sp_dn;

  // The pointer wraps as a circular stack, so overflow overwrites the oldest entry.
  always_comb begin
    sp_dn  = sp_r - AW'(1);
    sp_nxt = sp_r;
    if (push) begin
      sp_nxt = sp_r + AW'(1);
    end else if (pop) begin
      sp_nxt = sp_dn;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_r  <= '0;
      top_r <= '0;
    end else begin
      sp_r <= sp_nxt;
      if (push) begin
        mem_r[sp_r] <= push_data;
        top_r       <= push_data;
      end else if (pop) begin
        top_r <= mem_r[sp_dn - AW'(1)];
      end
    end
  end

endmodule : cix_stack
`default_nettype wire

// *** tb/cix_core_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module cix_core_test;
  import cix_pkg::*;
  logic           clk, nrst, stack_push, flush_seen, file_rd_r, file_we_r;
  logic           zero_r, global_irq_enable_r, phase_q1_r, flush_r, rd_exp;
  logic [IW-1:0]  instr;
  logic [PCW-1:0] pc_r, stack_push_data, p0;
  logic [FAW-1:0] file_addr_r;
  logic [DW-1:0]  file_rdata, file_wdata_r, w_r, option_r;
  int             bad_count, n_checks, cyc, n, r0;
  int             n_rd = 0;
  localparam int  CEIL = 2000;
  typedef struct packed {
    logic [IW-1:0] word; logic [FAW-1:0] addr; logic [DW-1:0] fval, w, f, opt; logic z;
  } cix_row_t;
  cix_row_t rows [0:12] = '{
    '{14'h3ab5, 7'h25, 8'h00, 8'hb5, 8'h00, 8'hff, 1'b0},
    '{14'h06a5, 7'h25, 8'haf, 8'hb5, 8'h1a, 8'hff, 1'b0},
    '{14'h067f, 7'h7f, 8'hb5, 8'h00, 8'hb5, 8'hff, 1'b1},
    '{14'h13a5, 7'h25, 8'hc7, 8'h00, 8'h47, 8'hff, 1'b1},
    '{14'h17a5, 7'h25, 8'h0a, 8'h00, 8'h8a, 8'hff, 1'b1},
    '{14'h1025, 7'h25, 8'hff, 8'h00, 8'hfe, 8'hff, 1'b1},
    '{14'h15ff, 7'h7f, 8'h00, 8'h00, 8'h08, 8'hff, 1'b1},
    '{14'h3a5a, 7'h25, 8'h00, 8'h5a, 8'h00, 8'hff, 1'b0},
    '{14'h0062, 7'h25, 8'h00, 8'h5a, 8'h00, 8'h5a, 1'b0},
    '{14'h0060, 7'h25, 8'h33, 8'h5a, 8'h33, 8'h5a, 1'b0},
    '{14'h0020, 7'h25, 8'h33, 8'h5a, 8'h33, 8'h5a, 1'b0},
    '{14'h0040, 7'h25, 8'h33, 8'h5a, 8'h33, 8'h5a, 1'b0},
    '{14'h0000, 7'h25, 8'h33, 8'h5a, 8'h33, 8'h5a, 1'b0}};

  cix_core dut (.clk(clk), .nrst(nrst), .instr(instr), .pc_r(pc_r),
    .file_rdata(file_rdata), .file_addr_r(file_addr_r), .file_rd_r(file_rd_r),
    .file_we_r(file_we_r), .file_wdata_r(file_wdata_r), .stack_push(stack_push),
    .stack_push_data(stack_push_data), .w_r(w_r), .option_r(option_r),
    .zero_r(zero_r), .global_irq_enable_r(global_irq_enable_r),
    .phase_q1_r(phase_q1_r), .flush_r(flush_r));
  cix_fmem fm (.clk(clk), .file_addr(file_addr_r), .file_we(file_we_r),
    .file_wdata(file_wdata_r), .file_rdata(file_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (flush_r === 1'b1) flush_seen <= 1'b1;
    if (file_rd_r === 1'b1) n_rd++;
    if (cyc == CEIL) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [PCW-1:0] exp, input logic [PCW-1:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wait_cyc(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_cyc

  // Moves to the cycle in which Q1 is active, counting edges in n.
  task automatic to_q1();
    n = 0;
    do begin
      wait_cyc(1);
      n++;
    end while (phase_q1_r !== 1'b1 && n < 9);
  endtask : to_q1

  task automatic exec(input logic [IW-1:0] word);
    to_q1();
    instr = word;
    wait_cyc(1);
    instr = NO_OPERATION;
  endtask : exec

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  initial begin
    nrst = 1'b0; instr = NO_OPERATION; stack_push = 1'b0; stack_push_data = '0;
    flush_seen = 1'b0; bad_count = 0; n_checks = 0; cyc = 0;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    foreach (rows[i]) begin
      fm.mem[rows[i].addr] = rows[i].fval;
      r0 = n_rd;
      rd_exp = (rows[i].word[13:12] == 2'b01) || (rows[i].word[13:8] == XOR_FILE_OP);
      exec(rows[i].word);
      wait_cyc(6);
      chk("w", rows[i].w, w_r);
      chk("file", rows[i].f, fm.mem[rows[i].addr]);
      chk("option", rows[i].opt, option_r);
      chk("zero", rows[i].z, zero_r);
      chk("reads", PCW'(rd_exp), PCW'(n_rd - r0));
    end
    $display("test rows done");
    // Clear bit skips the literal XOR; a set bit lets it run.
    fm.mem[7'h30] = 8'hfe;
    flush_seen = 1'b0;
    exec(14'h1830);
    exec(14'h3a0f);
    wait_cyc(6);
    chk("w skip", 8'h5a, w_r);
    chk("flush skip", 1'b1, flush_seen);
    flush_seen = 1'b0;
    exec(14'h18b0);
    exec(14'h3a0f);
    wait_cyc(6);
    chk("w noskip", 8'h55, w_r);
    chk("flush noskip", 1'b0, flush_seen);
    $display("test skip done");
    to_q1();
    p0 = pc_r;
    to_q1();
    chk("phase len", PCW'(PHASES), n[PCW-1:0]);
    chk("pc step", p0 + 13'h0001, pc_r);
    $display("test phase done");
    stack_push = 1'b1;
    stack_push_data = 13'h0123;
    wait_cyc(1);
    stack_push = 1'b0;
    exec(RETURN_FROM_INTERRUPT_OP);
    exec(14'h3aff);
    to_q1();
    chk("irq enable", 1'b1, global_irq_enable_r);
    chk("pc return", 13'h0124, pc_r);
    wait_cyc(6);
    chk("w after return", 8'h55, w_r);
    $display("test return done");
    nrst = 1'b0;
    wait_cyc(2);
    chk("w reset", W_RESET, w_r);
    chk("option reset", OPT_RESET, option_r);
    chk("irq enable reset", 1'b0, global_irq_enable_r);
    chk("pc reset", PC_RESET, pc_r);
    nrst = 1'b1;
    $display("test reset done");
    end_sim();
  end
endmodule : cix_core_test
`default_nettype wire

// *** tb/cix_fmem.sv ***
`timescale 1ns/1ps
`default_nettype none
module cix_fmem
  import cix_pkg::*;
(
  // Clock.
  input  wire logic           clk,
  // File register port.
  input  wire logic [FAW-1:0] file_addr,
  input  wire logic           file_we,
  input  wire logic [DW-1:0]  file_wdata,
  output logic      [DW-1:0]  file_rdata
);
  // Read data follows the address at once, as the core captures it early.
  logic [DW-1:0] mem [0:(1<<FAW)-1];
  assign file_rdata = mem[file_addr];
  always @(posedge clk) begin
    if (file_we) begin
      mem[file_addr] <= file_wdata;
    end
  end
endmodule : cix_fmem
`default_nettype wire
